// ===== hw/amf_pkg.sv
/*
 * Constants and types for the ARP violation MAC filter table.
 * Assumes one core clock at 100 MHz; all other figures are fixed here except the tick count, which the table takes as a parameter.
 */
package amf_pkg;

   // ************************************************************
   // Table geometry
   // ************************************************************
   localparam int unsigned AMF_ENTRIES  = 256;
   localparam logic [8:0]  AMF_MAX_CNT  = 9'h100;
   localparam int unsigned AMF_NPORT    = 8;
   localparam int unsigned AMF_IDX_W    = 8;
   localparam int unsigned AMF_PORT_W   = 3;
   localparam int unsigned AMF_LIFE_W   = 14;

   // ************************************************************
   // Lifetime limits, in minutes, and VLAN range
   // ************************************************************
   localparam logic [13:0] AMF_LIFE_MIN = 14'h0001;
   localparam logic [13:0] AMF_LIFE_MAX = 14'h2760;   // 10080
   localparam logic [11:0] AMF_VLAN_MIN = 12'h001;
   localparam logic [11:0] AMF_VLAN_MAX = 12'hFFE;    // 4094

   // ************************************************************
   // Timing
   // ************************************************************
   localparam longint AMF_CLK_HZ     = 64'h0000_0000_05F5_E100;  // 100 MHz
   localparam longint AMF_TICK_SEC   = 64'h0000_0000_0000_003C;  // 60 s
   localparam longint AMF_TICK_CYC   = AMF_TICK_SEC * AMF_CLK_HZ;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic        v;
      logic [47:0] mac;
      logic [11:0] vlan;
      logic [2:0]  port;
      logic [13:0] life;
   } amf_ent_t;

   typedef struct packed {
      amf_ent_t [255:0] tab;
      logic [32:0]      tick_cnt;
      logic             tick;
      logic             full_logged;
      logic [8:0]       count;
      logic             fwd;
      logic             drop;
      logic             log_ev;
      logic             blk;
      amf_ent_t         rd;
      logic [7:0]       ld_prev;
   } amf_state_t;

endpackage

// ===== hw/amf_filter_table.sv
/*
 * ARP violation MAC filter table: checks ARP packets, learns blocking
 * entries, ages them on a one-minute tick and serves management.
 * Assumes the binding lookup and rate policer sit outside and answer in
 * the same cycle as arp_valid_i; all inputs are synchronous to sys_clk_i.
 */
`timescale 1ns/1ns

module amf_filter_table
   import amf_pkg::*;
#(
   parameter logic [32:0] TICK_CYCLES = 33'(AMF_TICK_CYC)
)
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        insp_en_i,
   input  wire logic [7:0]  trusted_i,
   input  wire logic [13:0] age_min_i,
   input  wire logic        arp_valid_i,
   input  wire logic [47:0] arp_mac_i,
   input  wire logic [11:0] arp_vlan_i,
   input  wire logic [2:0]  arp_port_i,
   input  wire logic        bind_match_i,
   input  wire logic        rate_exceeded_i,
   input  wire logic        lk_valid_i,
   input  wire logic [47:0] lk_mac_i,
   input  wire logic [11:0] lk_vlan_i,
   input  wire logic [7:0]  link_down_i,
   input  wire logic        clr_all_i,
   input  wire logic        del_i,
   input  wire logic [47:0] del_mac_i,
   input  wire logic [11:0] del_vlan_i,
   input  wire logic [7:0]  rd_idx_i,
   output logic             fwd_o,
   output logic             drop_o,
   output logic             log_o,
   output logic             blk_o,
   output logic [8:0]       count_o,
   output logic             rd_valid_o,
   output logic [47:0]      rd_mac_o,
   output logic [11:0]      rd_vlan_o,
   output logic [2:0]       rd_port_o,
   output logic [13:0]      rd_life_o
);

   // ************************************************************
   // Reset release
   // ************************************************************
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'h1};
   end
   assign rst_n = rst_sync_q[1];

   // ************************************************************
   // State and next state
   // ************************************************************
   amf_state_t  s_q;
   amf_state_t  s_d;
   logic        bad;
   logic        hit;
   logic        lk_hit;
   logic        free_ok;
   logic [7:0]  free_idx;
   logic [13:0] age;
   logic        del_ok;
   logic        ld_left;

   always_comb
   begin
      amf_ent_t   e;
      logic [8:0] cnt;
      e       = '0;
      cnt     = 9'h000;
      s_d     = s_q;
      s_d.tick = 1'h0;
      hit     = 1'h0;
      lk_hit  = 1'h0;
      free_ok = 1'h0;
      free_idx = 8'h00;
      ld_left = 1'h0;

      // Minute tick; the count is a parameter so simulation can shorten it
      if (s_q.tick_cnt >= TICK_CYCLES - 33'h1)
      begin
         s_d.tick_cnt = 33'h0;
         s_d.tick     = 1'h1;
      end
      else
         s_d.tick_cnt = s_q.tick_cnt + 33'h1;

      // Out-of-range ages are clamped rather than refused
      if (age_min_i < AMF_LIFE_MIN)
         age = AMF_LIFE_MIN;
      else if (age_min_i > AMF_LIFE_MAX)
         age = AMF_LIFE_MAX;
      else
         age = age_min_i;

      // Untrusted ports under inspection only; trusted always pass
      bad    = insp_en_i && !trusted_i[arp_port_i];
      del_ok = del_i && del_vlan_i >= AMF_VLAN_MIN && del_vlan_i <= AMF_VLAN_MAX;

      for (int i = 0; i < AMF_ENTRIES; i++)
      begin
         if (s_q.tab[i].v && s_q.tab[i].mac == arp_mac_i && s_q.tab[i].vlan == arp_vlan_i)
            hit = 1'h1;
         if (s_q.tab[i].v && s_q.tab[i].mac == lk_mac_i && s_q.tab[i].vlan == lk_vlan_i)
            lk_hit = 1'h1;
         if (!s_q.tab[i].v && !free_ok)
         begin
            free_ok  = 1'h1;
            free_idx = i[7:0];
         end
         if (s_q.tab[i].v && s_q.ld_prev[s_q.tab[i].port])
            ld_left = 1'h1;

         e = s_q.tab[i];
         if (clr_all_i)
            e.v = 1'h0;
         if (link_down_i[e.port])
            e.v = 1'h0;
         if (del_ok && e.mac == del_mac_i && e.vlan == del_vlan_i)
            e.v = 1'h0;
         // Each entry counts down its own stored lifetime
         if (s_q.tick && e.v)
         begin
            if (e.life <= 14'h0001)
               e.v = 1'h0;
            e.life = e.life - 14'h0001;
         end
         s_d.tab[i] = e;
      end

      // Forwarding decision and learning
      s_d.fwd    = arp_valid_i && !(bad && (!bind_match_i || rate_exceeded_i));
      s_d.drop   = arp_valid_i && !s_d.fwd;
      s_d.log_ev = 1'h0;
      if (arp_valid_i && bad && !bind_match_i && !hit && !clr_all_i)
      begin
         if (free_ok)
            s_d.tab[free_idx] = '{v: 1'h1, mac: arp_mac_i, vlan: arp_vlan_i,
                                  port: arp_port_i, life: age};
         else
         begin
            // Log only on the first overflow until space appears again
            s_d.log_ev      = !s_q.full_logged;
            s_d.full_logged = 1'h1;
         end
      end
      else if (s_q.count < AMF_MAX_CNT)
         s_d.full_logged = 1'h0;

      for (int i = 0; i < AMF_ENTRIES; i++)
         cnt = cnt + {8'h00, s_d.tab[i].v};
      s_d.count   = cnt;
      s_d.rd      = s_q.tab[rd_idx_i];
      s_d.blk     = lk_valid_i && lk_hit;
      s_d.ld_prev = link_down_i;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign fwd_o      = s_q.fwd;
   assign drop_o     = s_q.drop;
   assign log_o      = s_q.log_ev;
   assign blk_o      = s_q.blk;
   assign count_o    = s_q.count;
   assign rd_valid_o = s_q.rd.v;
   assign rd_mac_o   = s_q.rd.mac;
   assign rd_vlan_o  = s_q.rd.vlan;
   assign rd_port_o  = s_q.rd.port;
   assign rd_life_o  = s_q.rd.life;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n);

   trusted_pass_a: assert property (arp_valid_i && trusted_i[arp_port_i]
                                    |=> fwd_o && !drop_o)
      else $error("trusted ARP packet was dropped");
   bind_drop_a: assert property (arp_valid_i && bad && !bind_match_i |=> drop_o && !fwd_o)
      else $error("mismatched ARP packet was forwarded");
   count_bound_a: assert property (count_o <= AMF_MAX_CNT)
      else $error("filter table count above limit");
   clear_all_a: assert property (clr_all_i |=> count_o == 9'h000)
      else $error("clear-all left valid entries");
   full_log_a: assert property (arp_valid_i && bad && !bind_match_i && !hit && !free_ok
                                && !clr_all_i |=> drop_o ##1 !log_o)
      else $error("full table did not drop or logged again");
   insert_grow_a: assert property (arp_valid_i && bad && !bind_match_i && !hit && free_ok
                                   && !clr_all_i && !del_i && link_down_i == 8'h00 && !s_q.tick
                                   |=> count_o == $past(count_o) + 9'h001)
      else $error("learned entry was not added");
   link_down_a: assert property (link_down_i != 8'h00 && !arp_valid_i |=> !ld_left)
      else $error("entry of a downed port survived");
   life_range_a: assert property (rd_valid_o |-> rd_life_o >= AMF_LIFE_MIN
                                  && rd_life_o <= AMF_LIFE_MAX)
      else $error("entry lifetime out of range");

   cov_insert: cover property (arp_valid_i && bad && !bind_match_i && free_ok ##1 drop_o);
   cov_full_log: cover property (log_o);
   cov_expire: cover property (s_q.tick && count_o != 9'h000 ##1 count_o < $past(count_o));
   cov_delete: cover property (del_ok && count_o != 9'h000);

endmodule

// ===== testbench/amf_bind_model.sv
/*
 * Binding database stand-in facing the filter table.
 * Assumes hosts whose MAC starts with byte 02 hold a valid binding.
 */
`timescale 1ns/1ns
module amf_bind_model
(
   input  wire logic [47:0] mac_i,
   output logic             match_o
);
   // Same-cycle answer, as the table samples it with the packet
   assign match_o = (mac_i[47:40] == 8'h02);
endmodule

// ===== testbench/test_amf_filter_table.sv
/*
 * Self-checking bench: learning, trust, aging, removal, overflow.
 * Assumes the minute tick is shortened to 20 cycles.
 */
`timescale 1ns/1ns
module test_amf_filter_table
   import amf_pkg::*;
;
   logic        clk, rst_b, en, av, rate, lv, clr, del, match;
   logic        fwd, drop, logv, blk, rv;
   logic [7:0]  trust, ld, idx;
   logic [13:0] age, rlife;
   logic [47:0] amac, lmac, dmac, rmac;
   logic [11:0] avl, lvl, dvl, rvl;
   logic [2:0]  aport, rport;
   logic [8:0]  cnt;
   int          n_fail = 0, checks = 0, cyc = 0;

   amf_filter_table #(.TICK_CYCLES(33'h14)) u_dut (
      .sys_clk_i(clk), .rst_b_i(rst_b), .insp_en_i(en), .trusted_i(trust),
      .age_min_i(age), .arp_valid_i(av), .arp_mac_i(amac), .arp_vlan_i(avl),
      .arp_port_i(aport), .bind_match_i(match), .rate_exceeded_i(rate),
      .lk_valid_i(lv), .lk_mac_i(lmac), .lk_vlan_i(lvl), .link_down_i(ld),
      .clr_all_i(clr), .del_i(del), .del_mac_i(dmac), .del_vlan_i(dvl),
      .rd_idx_i(idx), .fwd_o(fwd), .drop_o(drop), .log_o(logv), .blk_o(blk),
      .count_o(cnt), .rd_valid_o(rv), .rd_mac_o(rmac), .rd_vlan_o(rvl),
      .rd_port_o(rport), .rd_life_o(rlife));
   amf_bind_model u_bind (.mac_i(amac), .match_o(match));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Run should finish near 650 cycles; ceiling leaves ample margin
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         close_out();
      end
   end

   // ************************************************************
   // Bus and checking tasks
   // ************************************************************
   task automatic close_out();
      if (n_fail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic ok, input string s);
      checks++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("wrong value %0t %s", $time, s);
      end
   endtask
   task automatic arp(input logic [47:0] m, input logic [11:0] v, input logic [2:0] p,
                      input logic r);
      @(posedge clk);
      av <= 1'b1;
      amac <= m;
      avl <= v;
      aport <= p;
      rate <= r;
      @(posedge clk);
      av <= 1'b0;
      #1;
   endtask
   task automatic mop(input logic c, input logic d, input logic [11:0] v, input logic [7:0] l);
      @(posedge clk);
      clr <= c;
      del <= d;
      dmac <= 48'h0A0000000001;
      dvl <= v;
      ld <= l;
      @(posedge clk);
      {clr, del, ld} <= '0;
      #1;
   endtask
   task automatic look(input logic [11:0] v, input logic x);
      @(posedge clk);
      lv <= 1'b1;
      lmac <= 48'h0A0000000001;
      lvl <= v;
      @(posedge clk);
      lv <= 1'b0;
      #1;
      chk(blk === x, "lookup");
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_learn();
      arp(48'h0A0000000001, 12'h00A, 3'h5, 1'b0);
      chk(drop === 1'b1 && fwd === 1'b0 && cnt === 9'h001, "learn");
      @(posedge clk);
      @(posedge clk);
      #1;
      chk(rv === 1'b1 && rmac === 48'h0A0000000001 && rport === 3'h5, "entry");
      chk(rvl === 12'h00A && rlife >= 14'h275F && rlife <= AMF_LIFE_MAX, "life");
      look(12'h00A, 1'b1);
      look(12'h00B, 1'b0);
      arp(48'h0A0000000001, 12'h00A, 3'h5, 1'b0);
      chk(drop === 1'b1 && cnt === 9'h001, "duplicate");
      arp(48'h0200000000AA, 12'h00A, 3'h5, 1'b0);
      chk(fwd === 1'b1 && cnt === 9'h001, "bound host");
   endtask
   task automatic t_trust();
      @(posedge clk) trust <= 8'h20;
      arp(48'h0B0000000001, 12'h00A, 3'h5, 1'b0);
      chk(fwd === 1'b1 && cnt === 9'h001, "trusted");
      arp(48'h0200000000AB, 12'h00A, 3'h4, 1'b1);
      chk(drop === 1'b1 && cnt === 9'h001, "rate");
      @(posedge clk) trust <= 8'h00;
   endtask
   task automatic t_mgmt();
      arp(48'h0C0000000001, 12'h00A, 3'h6, 1'b0);
      @(posedge clk) idx <= 8'h01;
      repeat (2) @(posedge clk);
      #1;
      chk(rv === 1'b1 && rmac === 48'h0C0000000001 && rport === 3'h6 && rvl === 12'h00A,
          "index read");
      @(posedge clk) idx <= 8'h00;
      mop(1'b0, 1'b1, 12'h000, 8'h00);
      chk(cnt === 9'h002, "vlan zero");
      mop(1'b0, 1'b1, 12'h00A, 8'h00);
      chk(cnt === 9'h001, "delete");
      @(posedge clk) en <= 1'b0;
      mop(1'b0, 1'b0, 12'h000, 8'h40);
      chk(cnt === 9'h000, "link down");
      arp(48'h0C0000000003, 12'h00A, 3'h6, 1'b0);
      chk(fwd === 1'b1 && drop === 1'b0 && cnt === 9'h000, "inspection off");
      @(posedge clk) en <= 1'b1;
      arp(48'h0C0000000002, 12'h00A, 3'h6, 1'b0);
      mop(1'b1, 1'b0, 12'h000, 8'h00);
      chk(cnt === 9'h000, "clear");
   endtask
   task automatic t_age();
      @(posedge clk) age <= 14'h0003;
      arp(48'h0D0000000001, 12'h00A, 3'h1, 1'b0);
      @(posedge clk) age <= 14'h0000;
      arp(48'h0D0000000002, 12'h00A, 3'h1, 1'b0);
      repeat (25) @(posedge clk);
      #1;
      chk(cnt === 9'h001, "short life");
      chk(rv === 1'b1 && rlife >= 14'h0001 && rlife <= 14'h0002, "own lifetime");
      repeat (45) @(posedge clk);
      #1;
      chk(cnt === 9'h000, "expiry");
      @(posedge clk) age <= AMF_LIFE_MAX;
   endtask
   task automatic t_full();
      for (int i = 0; i < 256; i++)
         arp({40'hEE00000000, 8'(i)}, 12'h001, 3'h0, 1'b0);
      chk(cnt === AMF_MAX_CNT, "full");
      arp(48'hEF0000000001, 12'h001, 3'h0, 1'b0);
      chk(drop === 1'b1 && logv === 1'b1 && cnt === AMF_MAX_CNT, "overflow");
      arp(48'hEF0000000002, 12'h001, 3'h0, 1'b0);
      chk(drop === 1'b1 && logv === 1'b0, "log once");
   endtask

   initial
   begin
      {rst_b, av, rate, lv, clr, del, trust, ld, idx, amac, lmac, dmac} = '0;
      {avl, lvl, dvl, aport} = '0;
      en = 1'b1;
      age = 14'h3FFF;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_learn();
      t_trust();
      t_mgmt();
      t_age();
      t_full();
      close_out();
   end
endmodule
